// >>> rtl/avdr_pkg.sv
// Purpose : Shared constants and types for the async port video DMA reader
// Assumes : 50 MHz peripheral clock, synchronous active-low reset
// Notes   : Overview of the block's behaviour follows
// Overview of operation
// R01 - Each read access fetches one 32-bit word
// R02 - Cycle start asserts bank select, enable, strobe
// R03 - Strobe held for per-bank access delay
// R04 - Four banks, each with own select line
// R05 - Select follows strobe, plus configured hold cycles
// R06 - DMA split into bursts of eight reads
// R07 - Transfer count programmable up to 64k words
// R08 - Reads pause during descriptor reload
// R09 - Source brackets active video with timing preambles (the bench source only opens each line with the start-of-active-video code)
// R10 - Source delivers exactly 720 pixels per line
// R11 - Source may use separate sync pins instead
// R12 - Nine idle cycles follow each burst of eight
// R13 - Read data captured when strobe deasserts
package avdr_pkg;

   localparam int unsigned DATA_W        = 32;
   localparam int unsigned BANKS         = 4;
   localparam int unsigned BANK_W        = 2;
   localparam int unsigned DLY_W         = 4;
   localparam int unsigned CNT_W         = 17;
   localparam int unsigned BURST_LEN     = 8;
   localparam int unsigned BURST_GAP     = 9;
   localparam int unsigned RELOAD_CYC    = 4;
   localparam int unsigned FIFO_DEPTH    = 8;
   localparam logic [CNT_W-1:0] MAX_COUNT = 17'h1_0000;
   localparam logic [BANKS-1:0] SEL_IDLE  = 4'hF;

   typedef enum logic [2:0]
   {
      ST_IDLE   = 3'b000,
      ST_STROBE = 3'b001,
      ST_HOLD   = 3'b010,
      ST_GAP    = 3'b011,
      ST_RELOAD = 3'b100
   } avdr_state_t;

   typedef struct packed
   {
      logic [DLY_W-1:0] access_cyc;
      logic [DLY_W-1:0] hold_cyc;
   } avdr_bank_cfg_t;

   typedef struct packed
   {
      logic [BANK_W-1:0] bank;
      logic [CNT_W-1:0]  count;
      logic              last;
   } avdr_desc_t;

endpackage

// >>> rtl/avdr_fifo.sv
// Purpose : Small synchronous FIFO in the read data path
// Assumes : Single clock, write and read may happen in the same cycle
// Notes   : Read data comes from a register
`timescale 1ns/100ps
`default_nettype none
module avdr_fifo
#(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 8
)
(
   // Clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             rst_n_i,
   input  wire logic             ce_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             ov_q, ov_d;
   logic [WIDTH-1:0] od_q, od_d;
   logic             wr, pop, load;

   // Output register is refilled whenever it is empty or being taken
   always_comb
   begin
      wr    = in_valid_i && (cnt_q != (AW+1)'(DEPTH));
      load  = (cnt_q != '0) && (!ov_q || out_ready_i);
      pop   = load;
      wp_d  = wr ? wp_q + AW'(1) : wp_q;
      rp_d  = pop ? rp_q + AW'(1) : rp_q;
      cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(pop);
      ov_d  = load ? 1'b1 : (out_ready_i ? 1'b0 : ov_q);
      od_d  = load ? mem_q[rp_q] : od_q;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
         ov_q  <= 1'b0;
         od_q  <= '0;
      end
      else if (ce_i)
      begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
         ov_q  <= ov_d;
         od_q  <= od_d;
         if (wr)
            mem_q[wp_q] <= in_data_i;
      end
   end

   assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = ov_q;
   assign out_data_o  = od_q;
endmodule
`default_nettype wire

// >>> rtl/avdr_bank_timer.sv
// Purpose : Loadable cycle down-counter for the per-bank timing phases
// Assumes : Bank configuration held stable during an access
// Notes   : Loads the delay for a phase, counts it down and flags its last cycle
`timescale 1ns/100ps
`default_nettype none
module avdr_bank_timer
   import avdr_pkg::*;
(
   // Clock and reset
   input  wire logic                             clk_sys_i,
   input  wire logic                             rst_n_i,
   input  wire logic                             ce_i,
   // Load and count
   input  wire logic                             load_i,
   input  wire logic [avdr_pkg::DLY_W-1:0]       value_i,
   output logic                                  done_o
);
   logic [DLY_W-1:0] cnt_q, cnt_d;

   always_comb
   begin
      if (load_i)
         cnt_d = value_i;
      else if (cnt_q != '0)
         cnt_d = cnt_q - DLY_W'(1);
      else
         cnt_d = cnt_q;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
         cnt_q <= '0;
      else if (ce_i)
         cnt_q <= cnt_d;
   end

   assign done_o = (cnt_q == DLY_W'(1)) || (cnt_q == '0);
endmodule
`default_nettype wire

// >>> rtl/avdr_reader.sv
// Purpose : Async memory port read engine run under DMA descriptors
// Assumes : Inputs synchronous to clk_sys_i; descriptor offered by valid/ready
// Notes   : Fetched words pass through an 8-word FIFO to the consumer
`timescale 1ns/100ps
`default_nettype none
module avdr_reader
   import avdr_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                              clk_sys_i,
   input  wire logic                              rst_n_i,
   input  wire logic                              ce_i,
   // Per-bank timing configuration
   input  wire avdr_pkg::avdr_bank_cfg_t [3:0]    bank_cfg_i,
   // Descriptor input
   input  wire logic                              desc_valid_i,
   input  wire avdr_pkg::avdr_desc_t              desc_i,
   output logic                                   desc_ready_o,
   // External async port
   output logic [avdr_pkg::BANKS-1:0]             bank_select_n_o,
   output logic                                   bus_output_enable_n_o,
   output logic                                   read_strobe_n_o,
   input  wire logic [avdr_pkg::DATA_W-1:0]       ext_data_i,
   // Word stream out
   output logic                                   word_valid_o,
   input  wire logic                              word_ready_i,
   output logic [avdr_pkg::DATA_W-1:0]            word_data_o,
   // Status
   output logic                                   busy_o,
   output logic                                   done_o
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [BANKS-1:0] bank_decode(input logic [BANK_W-1:0] b);
      logic [BANKS-1:0] s;
      s = SEL_IDLE;
      s[b] = 1'b0;
      return s;
   endfunction

   function automatic logic [DLY_W-1:0] at_least_one(input logic [DLY_W-1:0] v);
      return (v == '0) ? DLY_W'(1) : v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State

   avdr_state_t       st_q, st_d;
   logic [BANK_W-1:0] bank_q, bank_d;
   logic [CNT_W-1:0]  left_q, left_d;
   logic              last_q, last_d;
   logic [2:0]        beat_q, beat_d;
   logic [3:0]        gap_q, gap_d;
   logic [BANKS-1:0]  sel_q, sel_d;
   logic              oe_q, oe_d;
   logic              re_q, re_d;
   logic              busy_q, busy_d;
   logic              done_q, done_d;
   logic              dready_q, dready_d;
   logic              cap_vld_q, cap_vld_d;
   logic [DATA_W-1:0] cap_q, cap_d;

   logic              t_load, t_done;
   logic [DLY_W-1:0]  t_val;
   logic              fifo_rdy;
   logic              rd_start, rd_end, rd_release, cap_take;
   logic [BANK_W-1:0] rd_bank;
   logic [DLY_W-1:0]  acc_eff [BANKS];
   logic [DLY_W-1:0]  hold_eff [BANKS];

   // Each bank's delays are resolved once so the engine only indexes them
   for (genvar g = 0; g < BANKS; g++)
   begin : g_bank
      assign acc_eff[g]  = at_least_one(bank_cfg_i[g].access_cyc);   // R03
      assign hold_eff[g] = bank_cfg_i[g].hold_cyc;                    // R05
   end

   avdr_bank_timer u_timer
   (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .load_i    (t_load),
      .value_i   (t_val),
      .done_o    (t_done)
   );

   // Capture register feeds the FIFO; a word waits here if the FIFO is full
   avdr_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk_sys_i   (clk_sys_i),
      .rst_n_i     (rst_n_i),
      .ce_i        (ce_i),
      .in_valid_i  (cap_vld_q),
      .in_ready_o  (fifo_rdy),
      .in_data_i   (cap_q),
      .out_valid_o (word_valid_o),
      .out_ready_i (word_ready_i),
      .out_data_o  (word_data_o)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      st_d       = st_q;
      bank_d     = bank_q;
      left_d     = left_q;
      last_d     = last_q;
      beat_d     = beat_q;
      gap_d      = gap_q;
      busy_d     = busy_q;
      done_d     = 1'b0;
      dready_d   = 1'b0;
      rd_start   = 1'b0;
      rd_end     = 1'b0;
      rd_release = 1'b0;
      rd_bank    = bank_q;
      cap_take   = 1'b0;
      t_load     = 1'b0;
      t_val      = acc_eff[bank_q];

      unique case (st_q)
         ST_IDLE:
         begin
            // Strobe only begins when the capture slot is free
            if (desc_valid_i && !dready_q && !cap_vld_q)
            begin
               dready_d = 1'b1;
               bank_d   = desc_i.bank;
               // Zero or oversize count means the largest transfer
               left_d   = (desc_i.count == '0 || desc_i.count > MAX_COUNT) ?
                          MAX_COUNT : desc_i.count;                           // R07
               last_d   = desc_i.last;
               beat_d   = '0;
               busy_d   = 1'b1;
               rd_start = 1'b1;                                              // R02
               rd_bank  = desc_i.bank;                                       // R04
               t_load   = 1'b1;
               t_val    = acc_eff[desc_i.bank];                              // R03
               st_d     = ST_STROBE;
            end
         end
         ST_STROBE:
         begin
            if (t_done)
            begin
               rd_end   = 1'b1;                                              // R03
               cap_take = 1'b1;                                              // R13
               left_d   = left_q - CNT_W'(1);
               beat_d   = beat_q + 3'(1);
               if (hold_eff[bank_q] != '0)
               begin
                  t_load = 1'b1;
                  t_val  = hold_eff[bank_q];
                  st_d   = ST_HOLD;                                          // R05
               end
               else
               begin
                  rd_release = 1'b1;                                         // R05
                  st_d       = ST_GAP;
                  gap_d = (beat_q == 3'(BURST_LEN - 1)) ? 4'(BURST_GAP) : 4'h0; // R06 R12
               end
            end
         end
         ST_HOLD:
         begin
            if (t_done)
            begin
               rd_release = 1'b1;                                            // R05
               st_d       = ST_GAP;
               gap_d      = (beat_q == '0) ? 4'(BURST_GAP) : 4'h0;           // R06 R12
            end
         end
         ST_GAP:
         begin
            if (gap_q != '0)
               gap_d = gap_q - 4'(1);                                        // R12
            else if (left_q == '0)
            begin
               gap_d = 4'(RELOAD_CYC);
               st_d  = ST_RELOAD;                                            // R08
            end
            else if (!cap_vld_q)
            begin
               rd_start = 1'b1;                                              // R02 R04
               t_load   = 1'b1;                                              // R03
               st_d     = ST_STROBE;
            end
         end
         ST_RELOAD:
         begin
            // External reads stay paused while the next descriptor loads
            if (gap_q != '0)
               gap_d = gap_q - 4'(1);                                        // R08
            else
            begin
               done_d = 1'b1;
               busy_d = !last_q && desc_valid_i;
               st_d   = ST_IDLE;
            end
         end
         default:
            st_d = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         st_q      <= ST_IDLE;
         bank_q    <= '0;
         left_q    <= '0;
         last_q    <= 1'b0;
         beat_q    <= '0;
         gap_q     <= '0;
         busy_q    <= 1'b0;
         done_q    <= 1'b0;
         dready_q  <= 1'b0;
      end
      else if (ce_i)
      begin
         st_q      <= st_d;
         bank_q    <= bank_d;
         left_q    <= left_d;
         last_q    <= last_d;
         beat_q    <= beat_d;
         gap_q     <= gap_d;
         busy_q    <= busy_d;
         done_q    <= done_d;
         dready_q  <= dready_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port drive

   // Strobe end and select release share a cycle when no hold is set
   always_comb
   begin
      sel_d = sel_q;
      oe_d  = oe_q;
      re_d  = re_q;
      if (rd_start)
      begin
         sel_d = bank_decode(rd_bank);                                    // R02 R04
         oe_d  = 1'b0;                                                    // R02
         re_d  = 1'b0;                                                    // R02
      end
      if (rd_end)
         re_d = 1'b1;                                                     // R03
      if (rd_release)
      begin
         sel_d = SEL_IDLE;                                                // R05
         oe_d  = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         sel_q <= SEL_IDLE;
         oe_q  <= 1'b1;
         re_q  <= 1'b1;
      end
      else if (ce_i)
      begin
         sel_q <= sel_d;
         oe_q  <= oe_d;
         re_q  <= re_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture register

   always_comb
   begin
      cap_d     = cap_q;
      cap_vld_d = cap_vld_q && !fifo_rdy;
      if (cap_take)
      begin
         cap_d     = ext_data_i;                                          // R01 R13
         cap_vld_d = 1'b1;                                                // R13
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         cap_vld_q <= 1'b0;
         cap_q     <= '0;
      end
      else if (ce_i)
      begin
         cap_vld_q <= cap_vld_d;
         cap_q     <= cap_d;
      end
   end

   assign bank_select_n_o       = sel_q;
   assign bus_output_enable_n_o = oe_q;
   assign read_strobe_n_o       = re_q;
   assign busy_o                = busy_q;
   assign done_o                = done_q;
   assign desc_ready_o          = dready_q;

endmodule
`default_nettype wire

// >>> bench/avdr_mem_model.sv
// Purpose : Buffered video source seen through the async read port
// Assumes : Word index advances once per completed read strobe
// Notes   : Outside a selected, enabled read the bus shows garbage
`timescale 1ns/100ps
`default_nettype none
module avdr_mem_model
   import avdr_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   // Async port
   input  wire logic [BANKS-1:0]  sel_n_i,
   input  wire logic              oe_n_i,
   input  wire logic              strobe_n_i,
   output logic      [DATA_W-1:0] data_o
);
   logic              prev_q;
   logic [23:0]       idx_q;
   logic [DATA_W-1:0] last_q;
   logic [DATA_W-1:0] word;
   logic [1:0]        bk;
   logic              drv;
   // Two pixels a word: a 720-pixel line is 360 words
   localparam logic [8:0] LINE_WORDS = 9'h168;
   logic [8:0]        pos_q;
   logic              active_video_valid;
   always_comb
   begin
      bk   = !sel_n_i[1] ? 2'h1 : !sel_n_i[2] ? 2'h2 : !sel_n_i[3] ? 2'h3 : 2'h0;
      // Each line opens with the start-of-active-video code
      active_video_valid = (pos_q != 9'h0);
      word = active_video_valid ? {6'h0, bk, idx_q} : 32'hFF00_00DA;
      drv  = !oe_n_i && (sel_n_i != SEL_IDLE);
      // Inverse of last word so a released bus never looks valid
      data_o = drv ? word : ~last_q;
   end
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         prev_q <= 1'b1;
         idx_q  <= 24'h0;
         pos_q  <= 9'h0;
         last_q <= 32'h0000_0000;
      end
      else
      begin
         prev_q <= strobe_n_i;
         if (!prev_q && strobe_n_i)
         begin
            idx_q <= idx_q + 24'h1;
            pos_q <= (pos_q == LINE_WORDS - 9'h1) ? 9'h0 : pos_q + 9'h1;
         end
         if (drv)
            last_q <= word;
      end
   end
endmodule
`default_nettype wire

// >>> bench/avdr_reader_chk.sv
// Purpose : Port-level timing checks of the async reader
// Assumes : Bound to avdr_reader
// Notes   : Gap and width counters are helper logic
`timescale 1ns/100ps
`default_nettype none
module avdr_reader_chk
   import avdr_pkg::*;
(
   input  wire logic                     clk_sys_i,
   input  wire logic                     rst_n_i,
   input  wire logic                     ce_i,
   input  wire avdr_bank_cfg_t [3:0]     bank_cfg_i,
   input  wire logic                     desc_ready_o,
   input  wire logic [BANKS-1:0]         bank_select_n_o,
   input  wire logic                     bus_output_enable_n_o,
   input  wire logic                     read_strobe_n_o,
   input  wire logic                     busy_o,
   input  wire logic                     done_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i || !ce_i);
   logic       prev_q;
   logic [3:0] lo_q;
   logic [3:0] hi_q;
   logic [3:0] need_q;
   logic [3:0] hold_q;
   logic [2:0] beat_q;
   logic [1:0] b;
   logic       fall;
   always_comb
   begin
      b = !bank_select_n_o[1] ? 2'h1 : !bank_select_n_o[2] ? 2'h2 :
          !bank_select_n_o[3] ? 2'h3 : 2'h0;
      fall = prev_q && !read_strobe_n_o;
   end
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         prev_q <= 1'b1;
         lo_q   <= 4'h0;
         hi_q   <= 4'h0;
         need_q <= 4'h0;
         hold_q <= 4'h0;
         beat_q <= 3'h0;
      end
      else if (ce_i)
      begin
         prev_q <= read_strobe_n_o;
         lo_q   <= read_strobe_n_o ? 4'h0 : lo_q + 4'h1;
         hi_q   <= !read_strobe_n_o ? 4'h0 : (hi_q == 4'hF ? hi_q : hi_q + 4'h1);
         if (fall)
            beat_q <= desc_ready_o ? 3'h1 : beat_q + 3'h1;
         if (!read_strobe_n_o)
         begin
            // Zero access setting behaves as one cycle
            need_q <= (bank_cfg_i[b].access_cyc == 4'h0) ? 4'h1 : bank_cfg_i[b].access_cyc;
            hold_q <= bank_cfg_i[b].hold_cyc;
         end
      end
   end
   a_strobe_framed: assert property (!read_strobe_n_o |-> !bus_output_enable_n_o
      && bank_select_n_o != SEL_IDLE) else $error("strobe without select or enable");
   a_one_bank: assert property ($countones(~bank_select_n_o) <= 1)
      else $error("more than one bank selected");
   a_ready_starts: assert property (desc_ready_o |-> $fell(read_strobe_n_o))
      else $error("descriptor taken without read start");
   a_ready_pulse: assert property (desc_ready_o |=> !desc_ready_o && busy_o)
      else $error("ready not a pulse or busy missing");
   a_done_pulse: assert property (done_o |=> !done_o)
      else $error("done longer than one cycle");
   a_strobe_width: assert property ($rose(read_strobe_n_o) |-> lo_q == need_q)
      else $error("strobe width differs from access setting");
   a_burst_gap: assert property (fall && !desc_ready_o && beat_q == 3'h0 |-> hi_q >= 4'h9)
      else $error("burst gap too short");
   a_reload_quiet: assert property (done_o |-> read_strobe_n_o && hi_q >= 4'h4)
      else $error("reads during descriptor reload");
   a_sel_release: assert property ($rose(read_strobe_n_o) && hold_q == 4'h0
      |-> bank_select_n_o == SEL_IDLE) else $error("select outlived strobe");
   a_sel_extend: assert property ($rose(read_strobe_n_o) && hold_q != 4'h0
      |-> bank_select_n_o != SEL_IDLE) else $error("hold cycles missing");
   c_take: cover property (desc_ready_o);
   c_gap: cover property (fall && !desc_ready_o && beat_q == 3'h0);
   c_done: cover property (done_o);
endmodule
bind avdr_reader avdr_reader_chk u_chk (.clk_sys_i, .rst_n_i, .ce_i, .bank_cfg_i, .desc_ready_o,
   .bank_select_n_o, .bus_output_enable_n_o, .read_strobe_n_o, .busy_o, .done_o);
`default_nettype wire

// >>> bench/avdr_reader_tb.sv
// Purpose : Self-checking bench of the async reader
// Assumes : Inputs driven 1 ns after the rising edge
// Notes   : Expected words rebuilt from the source's index sequence
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module avdr_reader_tb;
   import avdr_pkg::*;
   logic                 clk_sys_i = 1'b0;
   logic                 rst_n_i = 1'b0;
   logic                 desc_valid_i = 1'b0;
   logic                 word_ready_i = 1'b1;
   logic                 ce = 1'b1;
   avdr_bank_cfg_t [3:0] cfg = '0;
   avdr_desc_t           desc = '0;
   logic [BANKS-1:0]     sel_n;
   logic                 oe_n, strb_n, ready, wvalid, busy, done;
   logic [DATA_W-1:0]    ext_data, wdata, w;
   logic [23:0]          nidx = 24'h0;
   logic [DATA_W-1:0]    expq[$];
   logic                 prev_s = 1'b1;
   int                   fail_count = 0, compares = 0, reads = 0;
   avdr_reader uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce), .bank_cfg_i(cfg),
      .desc_valid_i(desc_valid_i), .desc_i(desc), .desc_ready_o(ready),
      .bank_select_n_o(sel_n), .bus_output_enable_n_o(oe_n), .read_strobe_n_o(strb_n),
      .ext_data_i(ext_data), .word_valid_o(wvalid), .word_ready_i(word_ready_i),
      .word_data_o(wdata), .busy_o(busy), .done_o(done));
   avdr_mem_model src (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sel_n_i(sel_n),
      .oe_n_i(oe_n), .strobe_n_i(strb_n), .data_o(ext_data));
   initial
   begin
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   task wrap_up();
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk_sys_i)
   begin
      if (prev_s && !strb_n)
         reads++;
      prev_s = strb_n;
      if (wvalid && word_ready_i && ce)
      begin
         w = (expq.size() > 0) ? expq.pop_front() : 32'hDEAD_0000;
         `CHK("word", w, wdata)
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One descriptor; with stall the consumer holds off through the clock-enable freeze and 300 more cycles
   task go(input logic [1:0] bk, input int n, input logic stall);
      int k;
      for (k = 0; k < n; k++)
      begin
         expq.push_back(nidx % 24'h168 == 24'h0 ? 32'hFF00_00DA : {6'h0, bk, nidx});
         nidx++;
      end
      reads = 0;
      word_ready_i = !stall;
      desc = '{bank: bk, count: 17'(n), last: 1'b1};
      desc_valid_i = 1'b1;
      k = 0;
      do @(posedge clk_sys_i); while (!ready && k++ < 50);
      `CHK("select", ~(4'h1 << bk), sel_n)
      `CHK("enable", 1'b0, oe_n)
      `CHK("busy", 1'b1, busy)
      #1 desc_valid_i = 1'b0;
      if (stall)
      begin
         // Clock enable low must hold the strobe well past its access time
         ce = 1'b0;
         repeat (16) @(posedge clk_sys_i);
         `CHK("frozen strobe", 1'b0, strb_n)
         `CHK("frozen select", ~(4'h1 << bk), sel_n)
         #1 ce = 1'b1;
         repeat (300) @(posedge clk_sys_i);
         // Capture register, eight FIFO words and the FIFO output register may be outstanding
         `CHK("stalled reads", 1'b1, reads >= 9 && reads <= 10)
         #1 word_ready_i = 1'b1;
      end
      k = 0;
      do @(posedge clk_sys_i); while (!done && k++ < 3000);
      `CHK("done", 1'b1, done)
      `CHK("idle", 1'b0, busy)
      `CHK("reads", n, reads)
      repeat (4) @(posedge clk_sys_i);
      `CHK("left", 0, expq.size())
      #1;
   endtask
   task t_burst();
      for (int b = 0; b < 4; b++)
         cfg[b] = '{access_cyc: 4'h2, hold_cyc: 4'h0};
      go(2'h1, 24, 1'b0);
      $display("test burst finished");
   endtask
   task t_banks();
      for (int b = 0; b < 4; b++)
      begin
         // Access 0 is the shortest boundary, hold grows per bank
         cfg[b] = '{access_cyc: 4'(b * 2), hold_cyc: 4'(b)};
         go(2'(b), 3, 1'b0);
      end
      $display("test banks finished");
   endtask
   task t_stall();
      go(2'h3, 20, 1'b1);
      $display("test stall finished");
   endtask
   initial
   begin
      repeat (12) @(posedge clk_sys_i);
      #1 rst_n_i = 1'b1;
      fork
         begin
            t_burst();
            t_banks();
            t_stall();
         end
         begin
            // Ceiling far above the several hundred cycles the tests need
            repeat (20000) @(posedge clk_sys_i);
            fail_count++;
            $display("timeout after 20000 cycles");
         end
      join_any
      wrap_up();
   end
endmodule
`default_nettype wire
